/* design/sjt_bsr.sv */
// Boundary register: pin synchroniser, capture/shift stage and update latch
`timescale 1ns/10ps
`default_nettype none
module sjt_bsr
    import sjt_pkg::*;
#(
    parameter int W = BSR_W
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-2:0] pin_in,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic preset,
    input wire logic tdi,
    output logic ser_out,
    output logic [W-1:0] upd_q
);
    logic [W-2:0] pin_m_q;
    logic [W-2:0] pin_s_q;
    logic [W-1:0] sh_q;

    // Two-stage synchroniser for the pin ring levels
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
        end else begin
            pin_m_q <= pin_in;
            pin_s_q <= pin_m_q;
        end
    end

    // Capture/shift stage, TDI enters at the MSB
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sh_q <= '0;
        end else if (capture) begin
            sh_q <= {upd_q[W-1], pin_s_q};
        end else if (shift) begin
            sh_q <= {tdi, sh_q[W-1:1]};
        end
    end

    assign ser_out = sh_q[0];

    // Update latch feeding the parallel outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            upd_q <= '0;
            upd_q[TRI_CELL] <= TRI_RESET_VAL;
        end else if (preset) begin
            upd_q[TRI_CELL] <= TRI_RESET_VAL;
        end else if (update) begin
            upd_q <= sh_q;
        end
    end

    a_tri_preset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        preset |=> upd_q[TRI_CELL]) else $error("tristate cell not preset");
    a_upd_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
        update && !preset |=> upd_q == $past(sh_q)) else $error("update lost");
endmodule
`default_nettype wire

/* design/sjt_pkg.sv */
// Constants, state type and decode helpers for the memory boundary-scan port
`default_nettype none
package sjt_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 109;
    localparam int TRI_CELL = 108;
    localparam int PIN_W = 108;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE_PRELOAD = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
    localparam logic [2:0] IR_RESET_VAL = 3'h1;
    localparam logic BYPASS_CAPTURE_VAL = 1'b0;
    localparam logic TRI_RESET_VAL = 1'b1;
    localparam int TLR_TMS_EDGES = 5;
    localparam int TCK_MAX_MHZ = 20;
    localparam int CLK_SYS_MHZ = 25;

    typedef enum logic [3:0] {
        ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
        ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
    } sjt_state_t;

    // True for instructions that place the boundary register on the path
    function automatic logic sjt_is_boundary(input logic [2:0] ins);
        sjt_is_boundary = (ins == INS_EXTEST) || (ins == INS_SAMPLE_Z) ||
                          (ins == INS_SAMPLE_PRELOAD);
    endfunction

    // True for instructions that use the bypass cell, reserved codes included
    function automatic logic sjt_is_bypass(input logic [2:0] ins);
        sjt_is_bypass = !sjt_is_boundary(ins) && (ins != INS_IDCODE);
    endfunction
endpackage
`default_nettype wire

/* design/sjt_tap.sv */
// Test access port: state machine, instruction, data paths and TDO driver
`timescale 1ns/10ps
`default_nettype none
module sjt_tap
    import sjt_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary identity value
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [PIN_W-1:0] bscan_pin_in,
    input wire logic core_q_oe,
    output logic q_oe,
    output logic bscan_drive,
    output logic [PIN_W-1:0] bscan_pin_out
);
    logic tck_m_q, tck_s_q, tck_d_q;
    logic tms_m_q, tms_s_q;
    logic tdi_m_q, tdi_s_q;
    logic tck_rise, tck_fall;
    sjt_state_t state_q, state_d;
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;
    logic [ID_W-1:0] id_q;
    logic byp_q;
    logic bsr_ser;
    logic [BSR_W-1:0] bsr_upd;
    logic sel_ser;
    logic tdo_q, tdo_oe_q;
    logic [2:0] tms_hi_cnt_q;

    // Two-stage synchronisers for the test pins, third stage for TCK edges
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tck_m_q <= 1'b0;
            tck_s_q <= 1'b0;
            tck_d_q <= 1'b0;
            tms_m_q <= 1'b1;
            tms_s_q <= 1'b1;
            tdi_m_q <= 1'b1;
            tdi_s_q <= 1'b1;
        end else begin
            tck_m_q <= tck;
            tck_s_q <= tck_m_q;
            tck_d_q <= tck_s_q;
            tms_m_q <= tms;
            tms_s_q <= tms_m_q;
            tdi_m_q <= tdi;
            tdi_s_q <= tdi_m_q;
        end
    end

    // Inputs act on rise, TDO on fall
    assign tck_rise = tck_s_q && !tck_d_q;
    assign tck_fall = !tck_s_q && tck_d_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_TLR: state_d = tms_s_q ? ST_TLR : ST_RTI;
            ST_RTI: state_d = tms_s_q ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_d = tms_s_q ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms_s_q ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_d = tms_s_q ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = tms_s_q ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: state_d = tms_s_q ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_d = tms_s_q ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: state_d = tms_s_q ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_d = tms_s_q ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_d = tms_s_q ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_d = tms_s_q ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = tms_s_q ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: state_d = tms_s_q ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_d = tms_s_q ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: state_d = tms_s_q ? ST_SEL_DR : ST_RTI;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= ST_TLR;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // Instruction shift stage
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ir_sh_q <= IR_CAPTURE_VAL;
        end else if (tck_rise && state_q == ST_CAP_IR) begin
            ir_sh_q <= IR_CAPTURE_VAL;
        end else if (tck_rise && state_q == ST_SH_IR) begin
            ir_sh_q <= {tdi_s_q, ir_sh_q[IR_W-1:1]};
        end
    end

    // Current instruction
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ir_q <= IR_RESET_VAL;
        end else if (state_q == ST_TLR) begin
            ir_q <= IR_RESET_VAL;
        end else if (tck_rise && state_q == ST_UP_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // Identity and bypass data registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            id_q <= ID_CODE;
            byp_q <= BYPASS_CAPTURE_VAL;
        end else if (tck_rise && state_q == ST_CAP_DR) begin
            id_q <= ID_CODE;
            byp_q <= BYPASS_CAPTURE_VAL;
        end else if (tck_rise && state_q == ST_SH_DR) begin
            id_q <= {tdi_s_q, id_q[ID_W-1:1]};
            byp_q <= tdi_s_q;
        end
    end

    sjt_bsr #(
        .W(BSR_W)
    ) u_bsr (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin_in(bscan_pin_in),
        .capture(tck_rise && state_q == ST_CAP_DR && sjt_is_boundary(ir_q)),
        .shift(tck_rise && state_q == ST_SH_DR && sjt_is_boundary(ir_q)),
        .update(tck_rise && state_q == ST_UP_DR && sjt_is_boundary(ir_q)),
        .preset(state_q == ST_TLR),
        .tdi(tdi_s_q),
        .ser_out(bsr_ser),
        .upd_q(bsr_upd)
    );

    always_comb begin
        if (state_q == ST_SH_IR) begin
            sel_ser = ir_sh_q[0];
        end else if (sjt_is_boundary(ir_q)) begin
            sel_ser = bsr_ser;
        end else if (sjt_is_bypass(ir_q)) begin
            sel_ser = byp_q;
        end else begin
            sel_ser = id_q[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= sel_ser;
            tdo_oe_q <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    assign bscan_drive = (ir_q == INS_EXTEST);
    assign bscan_pin_out = bsr_upd[PIN_W-1:0];

    always_comb begin
        unique case (ir_q)
            INS_SAMPLE_Z: q_oe = 1'b0;
            INS_EXTEST: q_oe = bsr_upd[TRI_CELL];
            default: q_oe = core_q_oe;
        endcase
    end

    // Count of consecutive TMS-high rises, for checking only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tms_hi_cnt_q <= 3'h0;
        end else if (tck_rise) begin
            tms_hi_cnt_q <= !tms_s_q ? 3'h0 : (tms_hi_cnt_q == 3'h7 ? 3'h7 : tms_hi_cnt_q + 3'h1);
        end
    end

    a_five_tms_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tck_rise && tms_s_q && tms_hi_cnt_q >= 3'(TLR_TMS_EDGES - 1) |=> state_q == ST_TLR)
        else $error("five TMS-high rises did not reset");
    a_tlr_idcode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == ST_TLR |=> ir_q == INS_IDCODE) else $error("IDCODE not current");
    a_ir_update_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(ir_q) |-> $past(state_q) == ST_TLR ||
        ($past(tck_rise) && $past(state_q) == ST_UP_IR)) else $error("ir changed early");
    a_capture_ir_01: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tck_rise && state_q == ST_CAP_IR |=> ir_sh_q[1:0] == 2'h1)
        else $error("capture-IR pattern wrong");
    a_tdo_on_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(tdo) || $changed(tdo_oe) |-> $past(tck_fall))
        else $error("TDO moved off TCK fall");
    a_samplez_hiz: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ir_q == INS_SAMPLE_Z |-> !q_oe) else $error("bus driven in SAMPLE Z");
    a_extest_tri: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ir_q == INS_EXTEST |-> q_oe == bsr_upd[TRI_CELL] && bscan_drive)
        else $error("EXTEST enable mismatch");
    a_bypass_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tck_rise && state_q == ST_CAP_DR |=> !byp_q) else $error("bypass not cleared");
    a_tlr_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tck_rise && state_q == ST_TLR && !tms_s_q |=> state_q == ST_RTI)
        else $error("TLR exit wrong");

    c_ir_load: cover property (@(posedge clk_sys) disable iff (!rst_b)
        tck_rise && state_q == ST_UP_IR);
    c_extest: cover property (@(posedge clk_sys) disable iff (!rst_b) ir_q == INS_EXTEST);
    c_samplez: cover property (@(posedge clk_sys) disable iff (!rst_b) ir_q == INS_SAMPLE_Z);
    c_dr_shift: cover property (@(posedge clk_sys) disable iff (!rst_b)
        tck_rise && state_q == ST_SH_DR && ir_q == INS_SAMPLE_PRELOAD);
endmodule
`default_nettype wire

/* testbench/sjt_ctl_model.sv */
// Board test controller model: drives test clock, mode and data pins
`timescale 1ns/10ps
`default_nettype none
module sjt_ctl_model (
    input wire logic clk_sys,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    event seen;
    logic seen_tdo;
    logic seen_oe;
    // Pins idle high like pull-ups; clock stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 320 ns test clock: low 200 ns, high 120 ns, output read before rise
    task automatic step(input logic m, input logic d, input logic note);
        @(negedge clk_sys);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk_sys);
        seen_tdo = tdo;
        seen_oe = tdo_oe;
        if (note) begin
            -> seen;
        end
        tck = 1'b1;
        repeat (3) @(negedge clk_sys);
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    endtask
    // Five mode-high rises, then park in idle
    task automatic reset_tap();
        repeat (5) step(1'b1, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
    endtask
    // Scan n bits from idle through capture, shift, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din);
        step(1'b1, 1'b1, 1'b0);
        if (ir) begin
            step(1'b1, 1'b1, 1'b0);
        end
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1);
        end
        step(1'b1, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the memory boundary-scan port
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sjt_pkg::*;
    localparam logic [31:0] TB_ID = 32'hc3a5_0f69; // Arbitrary identity value
    localparam int LIMIT = 40000;
    logic clk_sys, rst_b, tck, tms, tdi, tdo, tdo_oe, core_q_oe, q_oe, bscan_drive;
    logic [PIN_W-1:0] bscan_pin_in, bscan_pin_out, pre_q;
    logic cell_q;
    logic [1:0] exp_q[$];
    logic [2:0] codes [10] = '{3'h4, 3'h0, 3'h2, 3'h7, 3'h1, 3'h0, 3'h7, 3'h1, 3'h4, 3'h0};
    int error_cnt, n_tests, cyc;

    sjt_tap #(.ID_CODE(TB_ID)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .bscan_pin_in(bscan_pin_in),
        .core_q_oe(core_q_oe), .q_oe(q_oe), .bscan_drive(bscan_drive),
        .bscan_pin_out(bscan_pin_out));
    sjt_ctl_model ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));

    // Clock at 25 MHz
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Optional instruction load, then one data scan of n bits with expectations
    task automatic run_code(input logic [2:0] c, input int n, input logic ld, input logic t);
        logic [127:0] din;
        logic [127:0] cap;
        int len;
        din = {$urandom, $urandom, $urandom, $urandom};
        din[n-1] = t;
        bscan_pin_in = {$urandom, $urandom, $urandom, $urandom};
        core_q_oe = (c == INS_EXTEST) ? ~cell_q : 1'($urandom);
        if (ld) begin
            for (int i = 0; i < IR_W; i++) exp_q.push_back({1'b1, IR_CAPTURE_VAL[i]});
            ctl.scan(1'b1, IR_W, {125'h0, c});
        end
        @(negedge clk_sys);
        chk(bscan_drive, c == INS_EXTEST);
        chk(q_oe, (c == INS_EXTEST) ? cell_q : (c == INS_SAMPLE_Z) ? 1'b0 : core_q_oe);
        chk(tdo_oe, 1'b0);
        // Path length and content by code
        case (c)
            INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE_PRELOAD: begin
                len = BSR_W;
                cap = {19'h0, cell_q, bscan_pin_in};
            end
            INS_IDCODE: begin
                len = ID_W;
                cap = {96'h0, TB_ID};
            end
            default: begin
                len = 1;
                cap = 128'h0;
            end
        endcase
        for (int i = 0; i < n; i++) exp_q.push_back({1'b1, (i < len) ? cap[i] : din[i-len]});
        ctl.scan(1'b0, n, din);
        if (len == BSR_W) begin
            cell_q = din[n-1];
            pre_q = din[n-BSR_W +: PIN_W];
        end
        @(negedge clk_sys);
        chk(bscan_pin_out, pre_q);
        chk(q_oe, (c == INS_EXTEST) ? cell_q : (c == INS_SAMPLE_Z) ? 1'b0 : core_q_oe);
    endtask

    // Watcher: each noted output bit is compared against the oldest expectation
    initial begin
        forever begin
            @(ctl.seen);
            if (exp_q.size() == 0) begin
                chk(1'b1, 1'b0);
            end else begin
                chk({ctl.seen_oe, ctl.seen_tdo}, exp_q.pop_front());
            end
        end
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(9849));
        rst_b = 1'b0;
        core_q_oe = 1'b0;
        bscan_pin_in = '0;
        pre_q = '0;
        cell_q = TRI_RESET_VAL;
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Leave the reset state for idle before the first scan
        ctl.step(1'b0, 1'b1, 1'b0);
        run_code(INS_IDCODE, 40, 1'b0, 1'b1);
        for (int i = 0; i < 10; i++) run_code(codes[i], 111, 1'b1, i[1]);
        // Port reset presets tristate cell and instruction
        ctl.reset_tap();
        @(negedge clk_sys);
        cell_q = TRI_RESET_VAL;
        chk(bscan_drive, 1'b0);
        chk(q_oe, core_q_oe);
        run_code(INS_IDCODE, 34, 1'b0, 1'b0);
        run_code(INS_EXTEST, 111, 1'b1, 1'b1);
        repeat (4) @(negedge clk_sys);
        chk(exp_q.size(), 0);
        stop_test();
    end
endmodule
`default_nettype wire
